// ==== msc_pkg.sv ====
/*
 * msc_pkg: constants and carrier types for the MAC statistics counter bank
 * (excessive collisions, deferred transmits, carrier loss, received bytes).
 * Assumes the register space addresses words by index, one index per register.
 */
package msc_pkg;

    // register indices inside the MAC register space
    localparam int MSC_ADDR_W = 16;
    localparam logic [15:0] MSC_IDX_EXCESS_COL = 16'h003e;
    localparam logic [15:0] MSC_IDX_DEFERRED_TX = 16'h003f;
    localparam logic [15:0] MSC_IDX_CARRIER_LOSS = 16'h0040;
    localparam logic [15:0] MSC_IDX_RX_BYTES_LO = 16'h0041;
    localparam logic [15:0] MSC_IDX_RX_BYTES_HI = 16'h0042;

    // field widths and saturation points
    localparam int MSC_EXC_W = 10;
    localparam int MSC_DEF_W = 18;
    localparam int MSC_CRS_W = 10;
    localparam int MSC_RXB_W = 48;
    localparam int MSC_SAT_W = 18;
    localparam logic [9:0] MSC_EXC_MAX = 10'h3ff;
    localparam logic [17:0] MSC_DEF_MAX = 18'h3ffff;
    localparam logic [9:0] MSC_CRS_MAX = 10'h3ff;

    // field positions in the 48-bit received-byte total
    localparam int MSC_LO_MSB = 31;
    localparam int MSC_HI_LSB = 32;
    localparam int MSC_HI_MSB = 47;

    // reset values
    localparam logic [9:0] MSC_EXC_RST = 10'h000;
    localparam logic [17:0] MSC_DEF_RST = 18'h00000;
    localparam logic [9:0] MSC_CRS_RST = 10'h000;
    localparam logic [47:0] MSC_RXB_RST = 48'h000000000000;
    localparam logic [31:0] MSC_RD_RST = 32'h00000000;

    // one-cycle event strobes from the MAC core
    typedef struct packed {
        logic excess_col_abort;
        logic deferred_tx_ok;
        logic carrier_loss_tx;
        logic rx_byte;
    } msc_ev_t;

    // register read request from the serial register interface
    typedef struct packed {
        logic en;
        logic [15:0] addr;
    } msc_rd_req_t;

endpackage

// ==== msc_stat_counters.sv ====
/*
 * msc_stat_counters: read-only, clear-on-read MAC statistics counter bank.
 * Assumes event strobes and read requests come from logic on ref_clk, so none
 * of them is synchronised; each read request is a single-cycle strobe.
 */
// Function
// R1: count excessive-collision aborts in 10 bits, hold at 0x3ff, clear on read.
// R2: with arbitration on, excess count should stay zero; increments flag misconfiguration.
// R3: count deferred-then-sent frames in 18 bits, hold at 0x3ffff, clear on read.
// R4: deferrals are still counted while collision avoidance arbitration is on.
// R5: count carrier-loss transmissions in 10 bits, hold at 0x3ff, clear on read.
// R6: keep 48-bit total of received bytes, destination address through FCS.
// R7: received-byte total wraps to zero past all ones instead of saturating.
// R8: low read returns bits 31:0 and latches upper bits for the high read.
// R9: high read returns bits 47:32 in bits 15:0, upper bits zero.
// R10: received-byte total clears only after low then high have been read.
// R11: host must read low register first, then high register.
// R12: unused register bits read zero; every counter is zero after reset.
// R13: an event coinciding with a clearing read is never lost.
`timescale 1ns/1ps

module msc_stat_counters
    import msc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire msc_ev_t events,
    input wire msc_rd_req_t rd_req,
    output logic [31:0] rd_data_q,
    output logic rd_valid_q
);

    function automatic logic [17:0] msc_sat_next(
        input logic [17:0] cur,
        input logic [17:0] max,
        input logic ev,
        input logic clr
    );
        if (clr)
        begin
            msc_sat_next = {17'h00000, ev};
        end
        else if (ev && (cur != max))
        begin
            msc_sat_next = cur + 18'h00001;
        end
        else
        begin
            msc_sat_next = cur;
        end
    endfunction

    logic [9:0] exc_q;
    logic [9:0] exc_d;
    logic [17:0] def_q;
    logic [17:0] def_d;
    logic [9:0] crs_q;
    logic [9:0] crs_d;
    logic [47:0] rxb_q;
    logic [47:0] rxb_d;
    logic [47:0] snap_q;
    logic [47:0] snap_d;
    logic lo_pend_q;
    logic lo_pend_d;
    logic [31:0] rd_data_d;

    wire logic rd_exc;
    wire logic rd_def;
    wire logic rd_crs;
    wire logic rd_lo;
    wire logic rd_hi;
    wire logic rxb_clr;
    wire logic [47:0] rxb_inc;
    wire logic [17:0] exc_full;
    wire logic [17:0] def_full;
    wire logic [17:0] crs_full;

    assign rd_exc = rd_req.en && (rd_req.addr == MSC_IDX_EXCESS_COL);
    assign rd_def = rd_req.en && (rd_req.addr == MSC_IDX_DEFERRED_TX);
    assign rd_crs = rd_req.en && (rd_req.addr == MSC_IDX_CARRIER_LOSS);
    assign rd_lo = rd_req.en && (rd_req.addr == MSC_IDX_RX_BYTES_LO);
    assign rd_hi = rd_req.en && (rd_req.addr == MSC_IDX_RX_BYTES_HI);

    // the read returns the old value, the cleared counter takes this cycle's event
    assign exc_full = msc_sat_next({8'h00, exc_q}, {8'h00, MSC_EXC_MAX}, events.excess_col_abort, rd_exc); // see R1, R13
    assign exc_d = exc_full[9:0];
    // no gating by arbitration mode: an abort under arbitration is a fault worth seeing
    // see R2
    assign def_full = msc_sat_next(def_q, MSC_DEF_MAX, events.deferred_tx_ok, rd_def); // see R3, R4, R13
    assign def_d = def_full;
    assign crs_full = msc_sat_next({8'h00, crs_q}, {8'h00, MSC_CRS_MAX}, events.carrier_loss_tx, rd_crs); // see R5, R13
    assign crs_d = crs_full[9:0];

    // one strobe per received byte, destination address through FCS
    assign rxb_inc = {47'h000000000000, events.rx_byte}; // see R6
    // clearing subtracts the snapshot instead of zeroing, so bytes that
    // arrive between the low and the high read survive the clear
    assign rxb_clr = rd_hi && lo_pend_q; // see R10, R11
    assign rxb_d = rxb_clr ? (rxb_q - snap_q + rxb_inc) : (rxb_q + rxb_inc); // see R7, R13
    assign snap_d = rd_lo ? rxb_q : snap_q; // see R8
    assign lo_pend_d = rd_lo ? 1'b1 : (rd_hi ? 1'b0 : lo_pend_q);

    // unmapped indices and unused bits read zero
    assign rd_data_d = rd_exc ? {22'h000000, exc_q} :
                       rd_def ? {14'h0000, def_q} :
                       rd_crs ? {22'h000000, crs_q} :
                       rd_lo ? rxb_q[MSC_LO_MSB:0] :
                       rd_hi ? {16'h0000, snap_q[MSC_HI_MSB:MSC_HI_LSB]} : // see R9
                       MSC_RD_RST; // see R12

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            exc_q <= MSC_EXC_RST; // see R12
            def_q <= MSC_DEF_RST;
            crs_q <= MSC_CRS_RST;
            rxb_q <= MSC_RXB_RST;
            snap_q <= MSC_RXB_RST;
            lo_pend_q <= 1'b0;
        end
        else
        begin
            exc_q <= exc_d;
            def_q <= def_d;
            crs_q <= crs_d;
            rxb_q <= rxb_d;
            snap_q <= snap_d;
            lo_pend_q <= lo_pend_d;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rd_data_q <= MSC_RD_RST;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_req.en;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking

    default disable iff (rst);

    sequence seq_lo_read_quiet;
        rd_lo && !events.rx_byte;
    endsequence

    sequence seq_hi_read_quiet;
        rd_hi && !events.rx_byte;
    endsequence

    sequence seq_lo_read_busy;
        rd_lo && events.rx_byte;
    endsequence

    sequence seq_hi_read_busy;
        rd_hi && events.rx_byte;
    endsequence

    chk_exc_hold_max: assert property ( // see R1
        (exc_q == MSC_EXC_MAX) && events.excess_col_abort && !rd_exc |=> exc_q == MSC_EXC_MAX
    ) else $error("excess collision count left its maximum");

    chk_exc_read_clear: assert property ( // see R1, R13
        rd_exc |=> (rd_data_q == {22'h000000, $past(exc_q)}) && (exc_q == {9'h000, $past(events.excess_col_abort)})
    ) else $error("excess collision read did not return and clear");

    chk_def_count_up: assert property ( // see R3, R4
        events.deferred_tx_ok && !rd_def && (def_q != MSC_DEF_MAX) |=> def_q == $past(def_q) + 18'h00001
    ) else $error("deferred count did not advance");

    chk_def_hold_max: assert property ( // see R3
        (def_q == MSC_DEF_MAX) && !rd_def |=> def_q == MSC_DEF_MAX
    ) else $error("deferred count rolled over");

    chk_crs_read_event: assert property ( // see R5, R13
        rd_crs && events.carrier_loss_tx |=> (crs_q == 10'h001) && (rd_data_q[31:10] == 22'h000000)
    ) else $error("carrier loss event lost on read");

    chk_crs_hold_max: assert property ( // see R5
        (crs_q == MSC_CRS_MAX) && !rd_crs |=> crs_q == MSC_CRS_MAX
    ) else $error("carrier loss count rolled over");

    chk_rxb_wraps: assert property ( // see R6, R7
        (rxb_q == 48'hffffffffffff) && events.rx_byte && !rxb_clr |=> rxb_q == 48'h000000000000
    ) else $error("received byte total did not wrap");

    chk_rxb_low_snap: assert property ( // see R8
        rd_lo |=> (rd_data_q == $past(rxb_q[MSC_LO_MSB:0])) && (snap_q == $past(rxb_q)) && lo_pend_q
    ) else $error("low read did not latch the upper bits");

    chk_rxb_high_word: assert property ( // see R9
        rd_hi |=> rd_data_q == {16'h0000, $past(snap_q[MSC_HI_MSB:MSC_HI_LSB])}
    ) else $error("high read returned wrong bits");

    chk_rxb_pair_clear: assert property ( // see R10
        seq_lo_read_quiet ##1 seq_hi_read_quiet |=> rxb_q == 48'h000000000000
    ) else $error("byte total not cleared after low and high reads");

    chk_rxb_no_lone_clear: assert property ( // see R10
        rd_hi && !lo_pend_q |=> rxb_q == $past(rxb_q) + $past(rxb_inc)
    ) else $error("high read alone cleared the byte total");

    chk_rxb_keep_bytes: assert property ( // see R13
        seq_lo_read_busy ##1 seq_hi_read_busy |=> rxb_q == 48'h000000000002
    ) else $error("bytes lost across the clearing pair");

    // the default disable would switch this one off for good, so it opts out
    chk_reset_zero: assert property ( // see R12
        @(posedge ref_clk) disable iff (1'b0)
        rst |=> (exc_q == 10'h000) && (def_q == 18'h00000) && (crs_q == 10'h000)
            && (rxb_q == 48'h000000000000) && (snap_q == 48'h000000000000) && !lo_pend_q
            && !rd_valid_q && (rd_data_q == 32'h00000000)
    ) else $error("counters not zero after reset");

    chk_unmapped_zero: assert property ( // see R12
        rd_req.en && !(rd_exc || rd_def || rd_crs || rd_lo || rd_hi) |=> rd_valid_q && (rd_data_q == 32'h00000000)
    ) else $error("unmapped read returned nonzero data");

    // small counters: step, hold, read and clear
    chk_exc_count_up: assert property ( // see R1, R2
        events.excess_col_abort && !rd_exc && (exc_q != MSC_EXC_MAX) |=> exc_q == $past(exc_q) + 10'h001
    ) else $error("excess collision count did not advance");

    chk_exc_idle_hold: assert property ( // see R1
        !events.excess_col_abort && !rd_exc |=> $stable(exc_q)
    ) else $error("excess collision count moved without an event");

    chk_exc_sat_read: assert property ( // see R1, R13
        rd_exc && (exc_q == MSC_EXC_MAX) |=> rd_data_q == {22'h000000, MSC_EXC_MAX}
    ) else $error("saturated excess collision count read wrong");

    chk_def_read_clear: assert property ( // see R3, R13
        rd_def |=> (rd_data_q == {14'h0000, $past(def_q)}) && (def_q == {17'h00000, $past(events.deferred_tx_ok)})
    ) else $error("deferred read did not return and clear");

    chk_def_idle_hold: assert property ( // see R3
        !events.deferred_tx_ok && !rd_def |=> $stable(def_q)
    ) else $error("deferred count moved without an event");

    chk_def_upper_zero: assert property ( // see R12
        rd_def |=> rd_data_q[31:18] == 14'h0000
    ) else $error("deferred read showed unused bits");

    chk_crs_count_up: assert property ( // see R5
        events.carrier_loss_tx && !rd_crs && (crs_q != MSC_CRS_MAX) |=> crs_q == $past(crs_q) + 10'h001
    ) else $error("carrier loss count did not advance");

    chk_crs_read_clear: assert property ( // see R5, R13
        rd_crs |=> (rd_data_q == {22'h000000, $past(crs_q)}) && (crs_q == {9'h000, $past(events.carrier_loss_tx)})
    ) else $error("carrier loss read did not return and clear");

    chk_crs_idle_hold: assert property ( // see R5
        !events.carrier_loss_tx && !rd_crs |=> $stable(crs_q)
    ) else $error("carrier loss count moved without an event");

    chk_crs_sat_read: assert property ( // see R5, R13
        rd_crs && (crs_q == MSC_CRS_MAX) |=> rd_data_q == {22'h000000, MSC_CRS_MAX}
    ) else $error("saturated carrier loss count read wrong");

    // byte total: counting, snapshot and the pending low read
    chk_rxb_count_up: assert property ( // see R6, R7
        !rxb_clr |=> rxb_q == $past(rxb_q) + {47'h000000000000, $past(events.rx_byte)}
    ) else $error("received byte total did not follow the strobes");

    chk_snap_hold: assert property ( // see R8
        !rd_lo |=> $stable(snap_q)
    ) else $error("snapshot changed without a low read");

    chk_pend_drop: assert property ( // see R10
        rd_hi |=> !lo_pend_q
    ) else $error("pending low read survived a high read");

    chk_pend_hold: assert property ( // see R10
        !rd_lo && !rd_hi |=> $stable(lo_pend_q)
    ) else $error("pending low read changed on its own");

    chk_hi_pair_word: assert property ( // see R8, R9
        seq_lo_read_quiet ##1 rd_hi |=> rd_data_q == {16'h0000, $past(rxb_q[MSC_HI_MSB:MSC_HI_LSB], 2)}
    ) else $error("high read did not match the low read's total");

    chk_hi_upper_zero: assert property ( // see R9, R12
        rd_hi |=> rd_data_q[31:16] == 16'h0000
    ) else $error("high read showed unused bits");

    // read port: one answer per strobe, data zero when idle
    chk_read_answer: assert property ( // see R1, R3, R5
        rd_req.en |=> rd_valid_q
    ) else $error("read strobe got no answer");

    chk_no_stray_valid: assert property ( // see R12
        !rd_req.en |=> !rd_valid_q
    ) else $error("answer without a read strobe");

    chk_data_idle_zero: assert property ( // see R12
        !rd_req.en |=> rd_data_q == 32'h00000000
    ) else $error("read data not zero while idle");

endmodule

// ==== msc_host.sv ====
/*
 * msc_host: behavioural host that reads the statistics counter bank.
 * Assumes ref_clk comes from the bench; the bench calls the read tasks.
 */
`timescale 1ns/1ps

module msc_host
    import msc_pkg::*;
(
    input wire logic ref_clk,
    output msc_rd_req_t rd_req
);
    initial rd_req = '{en: 1'b0, addr: 16'h5a5a};

    task automatic rd(input logic [15:0] a);
        @(negedge ref_clk);
        rd_req.en = 1'b1;
        rd_req.addr = a;
        @(negedge ref_clk);
        rd_req.en = 1'b0;
        rd_req.addr = ~a; // idle index must not look like the last one
    endtask

    // low then high on consecutive edges, the tightest order a host can use
    task automatic rd_bytes();
        @(negedge ref_clk);
        rd_req.en = 1'b1;
        rd_req.addr = MSC_IDX_RX_BYTES_LO;
        @(negedge ref_clk);
        rd_req.addr = MSC_IDX_RX_BYTES_HI;
        @(negedge ref_clk);
        rd_req.en = 1'b0;
        rd_req.addr = 16'h5a5a;
    endtask
endmodule

// ==== tb_mac_tx_rx_statistics_counters.sv ====
/*
 * tb_mac_tx_rx_statistics_counters: self-checking bench for msc_stat_counters.
 * Assumes msc_pkg and msc_host are compiled first; host reads and events change at falling edges.
 */
`timescale 1ns/1ps

module tb_mac_tx_rx_statistics_counters;
    import msc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    msc_ev_t events = '0;
    msc_rd_req_t rd_req;
    logic [31:0] rd_data_q;
    logic rd_valid_q;
    int n_fail = 0;
    int checks_done = 0;
    logic [31:0] exp_q[$];
    logic [9:0] exc, crs;
    logic [17:0] def;
    logic [47:0] rxb, snap;
    logic pend;
    logic [3:0] ev_mask = 4'h0;
    logic [3:0] ev_force = 4'h0;

    always #4 ref_clk = ~ref_clk;

    msc_stat_counters u_dut(.ref_clk(ref_clk), .rst(rst), .events(events), .rd_req(rd_req),
        .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));
    msc_host u_host(.ref_clk(ref_clk), .rd_req(rd_req));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wait_drain(input string name);
        for (int i = 0; i < 8 && exp_q.size() != 0; i++)
            @(negedge ref_clk);
        if (exp_q.size() != 0)
        begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, 32'h0, 32'(exp_q.size()));
            print_verdict();
        end
        else
            $display("test %s done", name);
    endtask

    always @(negedge ref_clk)
        events <= ev_force | (ev_mask & 4'($urandom));

    // reference model: answer is the value before this edge, then clear, then count
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            {exc, crs, def, rxb, snap, pend} = '0;
        end
        else
        begin
            if (rd_req.en)
            begin
                case (rd_req.addr)
                    MSC_IDX_EXCESS_COL: begin exp_q.push_back({22'h0, exc}); exc = '0; end
                    MSC_IDX_DEFERRED_TX: begin exp_q.push_back({14'h0, def}); def = '0; end
                    MSC_IDX_CARRIER_LOSS: begin exp_q.push_back({22'h0, crs}); crs = '0; end
                    MSC_IDX_RX_BYTES_LO: begin exp_q.push_back(rxb[31:0]); snap = rxb; pend = 1'b1; end
                    MSC_IDX_RX_BYTES_HI:
                    begin
                        exp_q.push_back({16'h0, snap[47:32]});
                        if (pend)
                            rxb = rxb - snap;
                        pend = 1'b0;
                    end
                    default: exp_q.push_back(32'h0);
                endcase
            end
            if (events.excess_col_abort && exc != MSC_EXC_MAX) exc = exc + 1'b1;
            if (events.deferred_tx_ok && def != MSC_DEF_MAX) def = def + 1'b1;
            if (events.carrier_loss_tx && crs != MSC_CRS_MAX) crs = crs + 1'b1;
            rxb = rxb + 48'(events.rx_byte);
        end
    end

    always @(negedge ref_clk)
    begin
        if (rd_valid_q === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(rd_data_q, 32'hffff_ffff);
            else
                chk(rd_data_q, exp_q.pop_front());
        end
    end

    initial
    begin
        void'($urandom(4));
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        for (int a = 16'h3d; a <= 16'h43; a++)
            u_host.rd(16'(a));
        wait_drain("reset_values");
        ev_mask = 4'hf;
        repeat (300)
        begin
            repeat ($urandom_range(0, 6)) @(negedge ref_clk);
            u_host.rd(16'h3e + 16'($urandom_range(0, 4)));
        end
        wait_drain("random_reads");
        ev_mask = 4'h0;
        ev_force = 4'b1010;
        repeat (1100) @(negedge ref_clk);
        u_host.rd(MSC_IDX_EXCESS_COL);
        u_host.rd(MSC_IDX_CARRIER_LOSS);
        ev_force = 4'h0;
        u_host.rd(MSC_IDX_EXCESS_COL);
        u_host.rd(MSC_IDX_CARRIER_LOSS);
        wait_drain("saturation");
        ev_force = 4'b0001;
        u_host.rd(MSC_IDX_RX_BYTES_HI);
        u_host.rd(MSC_IDX_RX_BYTES_LO);
        u_host.rd(MSC_IDX_RX_BYTES_LO);
        u_host.rd(MSC_IDX_DEFERRED_TX);
        u_host.rd(MSC_IDX_RX_BYTES_HI);
        u_host.rd(MSC_IDX_RX_BYTES_HI);
        u_host.rd_bytes();
        ev_force = 4'h0;
        u_host.rd_bytes();
        wait_drain("byte_pair");
        ev_mask = 4'hf;
        repeat (20) @(negedge ref_clk);
        ev_mask = 4'h0;
        rst = 1'b1;
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        for (int a = 16'h3e; a <= 16'h42; a++)
            u_host.rd(16'(a));
        wait_drain("mid_run_reset");
        print_verdict();
    end
endmodule
